// file: verilog/lpm_pkg.sv
package lpm_pkg;

  // ----------------------------------------
  // register map, 8-bit data
  // ----------------------------------------
  localparam int LPM_AW = 3;
  localparam int LPM_DW = 8;
  localparam logic [2:0] LPM_OFS_CTRL = 3'h0;
  localparam logic [2:0] LPM_OFS_CUC1 = 3'h1;
  localparam logic [2:0] LPM_OFS_CUC2 = 3'h2;
  localparam logic [2:0] LPM_OFS_GATE1 = 3'h3;
  localparam logic [2:0] LPM_OFS_GATE2 = 3'h4;
  localparam logic [2:0] LPM_OFS_STAT = 3'h5;

  // control register fields
  localparam int LPM_CTRL_LPR = 0;
  localparam int LPM_CTRL_WAKE_RUN = 1;
  localparam int LPM_CTRL_DBG = 2;
  localparam int LPM_CTRL_LVSE = 3;
  localparam int LPM_CTRL_LVD = 4;
  localparam int LPM_CTRL_DEEP = 5;
  localparam logic [5:0] LPM_CTRL_RST = 6'h00;

  // clock unit control fields
  localparam int LPM_CUC1_IRCLK = 0;
  localparam int LPM_CUC1_IRSTEN = 1;
  localparam int LPM_CUC2_ERCLK = 0;
  localparam int LPM_CUC2_ERSTEN = 1;
  localparam logic [1:0] LPM_CUC_RST = 2'h0;

  // peripheral gates: all clocks on after reset
  localparam logic [7:0] LPM_GATE_RST = 8'hff;

  // status fields
  localparam int LPM_STAT_MODE_LO = 0;
  localparam int LPM_STAT_BLOCK = 3;
  localparam logic [2:0] LPM_MODE_RUN = 3'h0;
  localparam logic [2:0] LPM_MODE_WAIT = 3'h1;
  localparam logic [2:0] LPM_MODE_LOW_POWER_RUN_MODE = 3'h2;
  localparam logic [2:0] LPM_MODE_LOW_POWER_WAIT_MODE = 3'h3;
  localparam logic [2:0] LPM_MODE_LSTOP = 3'h4;
  localparam logic [2:0] LPM_MODE_DSTOP = 3'h5;

  typedef enum logic [2:0] {
    ST_RUN, ST_WAIT, ST_LP_RUN, ST_LP_WAIT, ST_LIGHT_STOP, ST_DEEP_STOP
  } lpm_state_e;

  typedef enum logic [1:0] {REG_FULL, REG_STANDBY, REG_PARTIAL} lpm_regul_e;

  typedef struct packed {
    logic [LPM_AW-1:0] addr;
    logic [LPM_DW-1:0] wdata;
    logic wr;
    logic rd;
  } lpm_bus_s;

  typedef struct packed {
    logic stop_req;
    logic wait_req;
    logic wake_irq;
  } lpm_cpu_s;

  typedef struct packed {
    logic [15:0] periph_clk_en;
    logic debug_clk_en;
    logic cpu_clk_en;
    logic clock_unit_active;
    logic osc_run;
    lpm_regul_e regulator;
    logic adc_run_allowed;
    logic [2:0] mode;
  } lpm_pwr_s;

endpackage

// file: verilog/lpm_ctrl.sv
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// - any stop mode halts all peripheral clocks
// - debug enable keeps debug clock in light stop
// - low-power modes gate peripherals per gate registers
// - debug enable demotes deep stop to light
// - debug enable blocks low-power run and wait
// - low-voltage-stop enable demotes deep stop
// - low-voltage-stop enable blocks low-power modes
// - light stop clock unit needs both enables
// - stop oscillator runs only with both enables
// - light stop regulator full only with detector
// - converter runs low-power only on async clock
// - deep stop exits only on reset pin low
// - light stop wake: interrupt per request, reset
module lpm_ctrl
  import lpm_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire lpm_pkg::lpm_bus_s bus,
  output logic [lpm_pkg::LPM_DW-1:0] rdata,
  input wire lpm_pkg::lpm_cpu_s cpu,
  input wire logic reset_pin_low,
  input wire logic adc_async_clk_sel,
  output lpm_pkg::lpm_pwr_s pwr
);
  import lpm_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [5:0] ctrl_ff;
  logic [1:0] cuc1_ff;
  logic [1:0] cuc2_ff;
  logic [7:0] gate1_ff;
  logic [7:0] gate2_ff;
  logic [LPM_DW-1:0] rdata_ff;
  lpm_state_e state_ff;
  lpm_state_e nxt_state;
  logic lpr_hw_clr;
  logic lp_blocked;
  logic [2:0] mode_code;

  wire wr_ctrl = bus.wr && (bus.addr == LPM_OFS_CTRL);
  wire low_power_run_request = ctrl_ff[LPM_CTRL_LPR];
  wire wake_run = ctrl_ff[LPM_CTRL_WAKE_RUN];
  wire dbg_en = ctrl_ff[LPM_CTRL_DBG];
  wire lvse = ctrl_ff[LPM_CTRL_LVSE];
  wire lvd_en = ctrl_ff[LPM_CTRL_LVD];
  wire deep_sel = ctrl_ff[LPM_CTRL_DEEP];

  // either enable vetoes the deepest and the low-power modes
  assign lp_blocked = dbg_en | lvse;

  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      ctrl_ff <= LPM_CTRL_RST;
    else if (wr_ctrl)
      ctrl_ff <= bus.wdata[5:0];
    else if (lpr_hw_clr)
      ctrl_ff[LPM_CTRL_LPR] <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      cuc1_ff <= LPM_CUC_RST;
      cuc2_ff <= LPM_CUC_RST;
      gate1_ff <= LPM_GATE_RST;
      gate2_ff <= LPM_GATE_RST;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        LPM_OFS_CUC1: cuc1_ff <= bus.wdata[1:0];
        LPM_OFS_CUC2: cuc2_ff <= bus.wdata[1:0];
        LPM_OFS_GATE1: gate1_ff <= bus.wdata;
        LPM_OFS_GATE2: gate2_ff <= bus.wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (state_ff)
      ST_RUN: mode_code = LPM_MODE_RUN;
      ST_WAIT: mode_code = LPM_MODE_WAIT;
      ST_LP_RUN: mode_code = LPM_MODE_LOW_POWER_RUN_MODE;
      ST_LP_WAIT: mode_code = LPM_MODE_LOW_POWER_WAIT_MODE;
      ST_LIGHT_STOP: mode_code = LPM_MODE_LSTOP;
      ST_DEEP_STOP: mode_code = LPM_MODE_DSTOP;
      default: mode_code = LPM_MODE_RUN;
    endcase
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      rdata_ff <= 8'h00;
    else if (!bus.rd)
      rdata_ff <= 8'h00;
    else
    begin
      case (bus.addr)
        LPM_OFS_CTRL: rdata_ff <= {2'h0, ctrl_ff};
        LPM_OFS_CUC1: rdata_ff <= {6'h00, cuc1_ff};
        LPM_OFS_CUC2: rdata_ff <= {6'h00, cuc2_ff};
        LPM_OFS_GATE1: rdata_ff <= gate1_ff;
        LPM_OFS_GATE2: rdata_ff <= gate2_ff;
        LPM_OFS_STAT: rdata_ff <= {4'h0, lp_blocked, mode_code};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_ff;

  // ----------------------------------------
  // mode state
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    lpr_hw_clr = 1'b0;
    case (state_ff)
      ST_RUN:
      begin
        if (cpu.stop_req)
          nxt_state = (deep_sel && !lp_blocked) ? ST_DEEP_STOP : ST_LIGHT_STOP;
        else if (cpu.wait_req)
          nxt_state = ST_WAIT;
        else if (low_power_run_request && !lp_blocked)
          nxt_state = ST_LP_RUN;
      end
      ST_WAIT:
      begin
        if (cpu.wake_irq)
          nxt_state = ST_RUN;
      end
      ST_LP_RUN:
      begin
        if (!low_power_run_request || lp_blocked)
          nxt_state = ST_RUN;
        else if (cpu.stop_req)
          nxt_state = ST_LIGHT_STOP;
        else if (cpu.wait_req)
          nxt_state = ST_LP_WAIT;
        else if (cpu.wake_irq && wake_run)
        begin
          nxt_state = ST_RUN;
          lpr_hw_clr = 1'b1;
        end
      end
      ST_LP_WAIT:
      begin
        if (cpu.wake_irq)
        begin
          nxt_state = (wake_run || lp_blocked) ? ST_RUN : ST_LP_RUN;
          lpr_hw_clr = wake_run;
        end
        else if (lp_blocked)
          nxt_state = ST_WAIT;
      end
      ST_LIGHT_STOP:
      begin
        if (cpu.wake_irq)
        begin
          // interrupt returns to run unless low-power run is requested with wake_run clear and both vetoes clear
          nxt_state = (!low_power_run_request || wake_run || lp_blocked) ? ST_RUN : ST_LP_RUN;
          lpr_hw_clr = low_power_run_request && wake_run;
        end
      end
      ST_DEEP_STOP:
      begin
        // interrupts cannot wake it; only the pin does
        if (reset_pin_low)
        begin
          nxt_state = ST_RUN;
          lpr_hw_clr = 1'b1;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      state_ff <= ST_RUN;
    else
      state_ff <= nxt_state;
  end

  // ----------------------------------------
  // clock and power controls
  // ----------------------------------------
  lpm_pwr_s nxt_pwr;
  lpm_pwr_s pwr_ff;
  wire in_stop = (state_ff == ST_LIGHT_STOP) || (state_ff == ST_DEEP_STOP);
  wire [15:0] gates = {gate2_ff, gate1_ff};
  logic [15:0] periph_en;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_gate
      assign periph_en[gi] = !in_stop && gates[gi];
    end
  endgenerate

  always_comb
  begin
    nxt_pwr.periph_clk_en = periph_en;
    nxt_pwr.debug_clk_en = dbg_en && (state_ff != ST_DEEP_STOP);
    nxt_pwr.cpu_clk_en = (state_ff == ST_RUN) || (state_ff == ST_LP_RUN);
    nxt_pwr.mode = mode_code;
    nxt_pwr.osc_run = in_stop ? (cuc2_ff[LPM_CUC2_ERCLK] && cuc2_ff[LPM_CUC2_ERSTEN])
                              : cuc2_ff[LPM_CUC2_ERCLK];
    case (state_ff)
      ST_LIGHT_STOP:
      begin
        nxt_pwr.clock_unit_active = cuc1_ff[LPM_CUC1_IRCLK] && cuc1_ff[LPM_CUC1_IRSTEN];
        nxt_pwr.regulator = lvd_en ? REG_FULL : REG_STANDBY;
        nxt_pwr.adc_run_allowed = adc_async_clk_sel;
      end
      ST_DEEP_STOP:
      begin
        nxt_pwr.clock_unit_active = 1'b0;
        nxt_pwr.regulator = REG_PARTIAL;
        nxt_pwr.adc_run_allowed = 1'b0;
      end
      ST_LP_RUN, ST_LP_WAIT:
      begin
        nxt_pwr.clock_unit_active = 1'b1;
        nxt_pwr.regulator = REG_STANDBY;
        nxt_pwr.adc_run_allowed = adc_async_clk_sel;
      end
      default:
      begin
        nxt_pwr.clock_unit_active = 1'b1;
        nxt_pwr.regulator = REG_FULL;
        nxt_pwr.adc_run_allowed = 1'b1;
      end
    endcase
  end

  // outputs follow the mode one cycle later
  always_ff @(posedge clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      pwr_ff.periph_clk_en <= 16'hffff;
      pwr_ff.debug_clk_en <= 1'b0;
      pwr_ff.cpu_clk_en <= 1'b1;
      pwr_ff.clock_unit_active <= 1'b1;
      pwr_ff.osc_run <= 1'b0;
      pwr_ff.regulator <= REG_FULL;
      pwr_ff.adc_run_allowed <= 1'b1;
      pwr_ff.mode <= LPM_MODE_RUN;
    end
    else
      pwr_ff <= nxt_pwr;
  end

  assign pwr = pwr_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_light_wake_run;
    state_ff == ST_LIGHT_STOP && cpu.wake_irq && (!low_power_run_request || wake_run);
  endsequence

  sequence s_in_run;
    state_ff == ST_RUN;
  endsequence

  a_stop_gates_off: assert property (@(posedge clock) disable iff (!rst_n_ff)
    in_stop |=> pwr.periph_clk_en == 16'h0000)
    else $error("peripheral clock running in stop");

  a_debug_clock_on: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (state_ff == ST_LIGHT_STOP && dbg_en) |=> pwr.debug_clk_en)
    else $error("debug clock lost in stop");

  a_lp_gate_follow: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (state_ff == ST_LP_RUN || state_ff == ST_LP_WAIT) |=> pwr.periph_clk_en == $past(gates))
    else $error("peripheral gates not followed");

  a_deep_demote: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (s_in_run ##0 (cpu.stop_req && deep_sel && lp_blocked)) |=> state_ff == ST_LIGHT_STOP)
    else $error("deep stop entered while vetoed");

  a_lp_blocked: assert property (@(posedge clock) disable iff (!rst_n_ff)
    lp_blocked |=> state_ff != ST_LP_RUN)
    else $error("low-power run entered while vetoed");

  a_clock_unit: assert property (@(posedge clock) disable iff (!rst_n_ff)
    state_ff == ST_LIGHT_STOP |=>
      pwr.clock_unit_active == ($past(cuc1_ff[LPM_CUC1_IRCLK]) && $past(cuc1_ff[LPM_CUC1_IRSTEN])))
    else $error("clock unit state wrong in light stop");

  a_osc_stop: assert property (@(posedge clock) disable iff (!rst_n_ff)
    in_stop && !(cuc2_ff[LPM_CUC2_ERCLK] && cuc2_ff[LPM_CUC2_ERSTEN]) |=> !pwr.osc_run)
    else $error("oscillator running in stop without enables");

  a_regulator: assert property (@(posedge clock) disable iff (!rst_n_ff)
    state_ff == ST_LIGHT_STOP |=>
      pwr.regulator == ($past(lvd_en) ? REG_FULL : REG_STANDBY))
    else $error("regulator state wrong in light stop");

  a_adc_allow: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (state_ff != ST_RUN && state_ff != ST_WAIT && !adc_async_clk_sel) |=> !pwr.adc_run_allowed)
    else $error("converter allowed without async clock");

  a_deep_exit: assert property (@(posedge clock) disable iff (!rst_n_ff)
    state_ff == ST_DEEP_STOP |=> state_ff == ($past(reset_pin_low) ? ST_RUN : ST_DEEP_STOP))
    else $error("deep stop left without pin or kept with pin");

  a_light_wake: assert property (@(posedge clock) disable iff (!rst_n_ff)
    s_light_wake_run |=> s_in_run ##1 pwr.mode == LPM_MODE_RUN)
    else $error("light stop interrupt did not return to run");

  a_light_hold: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (state_ff == ST_LIGHT_STOP && !cpu.wake_irq) |=> state_ff == ST_LIGHT_STOP)
    else $error("light stop left without interrupt");

endmodule

// file: bench/lpm_cpu_model.sv
`timescale 1ns/1ps
// ----
// cpu core stand-in
// ----
module lpm_cpu_model
  import lpm_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [1:0] cmd,
  output lpm_pkg::lpm_cpu_s cpu
);
  lpm_cpu_s cpu_ff;
  lpm_cpu_s nxt_cpu;

  // opcodes retire as one-cycle pulses: 1 stop, 2 wait, 3 wake
  always_comb
  begin
    nxt_cpu = '0;
    nxt_cpu.stop_req = (cmd == 2'h1);
    nxt_cpu.wait_req = (cmd == 2'h2);
    nxt_cpu.wake_irq = (cmd == 2'h3);
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      cpu_ff <= '0;
    else
      cpu_ff <= nxt_cpu;
  end

  assign cpu = cpu_ff;
endmodule

// file: bench/tb_lpm_ctrl.sv
`timescale 1ns/1ps
module tb_lpm_ctrl;
  import lpm_pkg::*;

  localparam logic [1:0] DO_STOP = 2'h1;
  localparam logic [1:0] DO_WAIT = 2'h2;
  localparam logic [1:0] DO_WAKE = 2'h3;

  logic clock = 1'b0;
  logic arst_n = 1'b0;
  lpm_bus_s bus = '0;
  logic [1:0] cmd = 2'h0;
  logic reset_pin_low = 1'b0;
  logic adc_async_clk_sel = 1'b0;
  logic [LPM_DW-1:0] rdata;
  lpm_cpu_s cpu;
  lpm_pwr_s pwr;
  int num_errors = 0;
  int num_checks = 0;

  always #5 clock = ~clock;

  lpm_cpu_model lpm_cpu_model_i (.clock(clock), .arst_n(arst_n), .cmd(cmd), .cpu(cpu));
  lpm_ctrl lpm_ctrl_i (.clock(clock), .arst_n(arst_n), .bus(bus), .rdata(rdata), .cpu(cpu),
    .reset_pin_low(reset_pin_low), .adc_async_clk_sel(adc_async_clk_sel), .pwr(pwr));

  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // waits past the one-cycle lag of pwr behind the mode state
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic act(input logic [1:0] c);
    @(posedge clock);
    cmd <= c;
    @(posedge clock);
    cmd <= 2'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic pin_pulse();
    @(posedge clock);
    reset_pin_low <= 1'b1;
    @(posedge clock);
    reset_pin_low <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    chk(pwr.mode, LPM_MODE_RUN);
    chk(pwr.periph_clk_en, 16'hffff);
    chk(pwr.cpu_clk_en, 1'b1);
    rd(LPM_OFS_CTRL, 8'h00);
    rd(LPM_OFS_GATE2, LPM_GATE_RST);
    wr(LPM_OFS_STAT, 8'h07);
    rd(LPM_OFS_STAT, 8'h00);
    rd(3'h7, 8'h00);
  endtask

  task automatic t_low_power();
    wr(LPM_OFS_GATE1, 8'h0f);
    wr(LPM_OFS_GATE2, 8'ha5);
    // clock unit taken as already bypassed; bus rate lies outside this block
    wr(LPM_OFS_CTRL, 8'h01);
    chk(pwr.mode, LPM_MODE_LOW_POWER_RUN_MODE);
    chk(pwr.periph_clk_en, 16'ha50f);
    act(DO_WAIT);
    chk(pwr.mode, LPM_MODE_LOW_POWER_WAIT_MODE);
    chk(pwr.cpu_clk_en, 1'b0);
    chk(pwr.periph_clk_en, 16'ha50f);
    act(DO_WAKE);
    act(DO_STOP);
    chk(pwr.periph_clk_en, 16'h0000);
    act(DO_WAKE);
    chk(pwr.mode, LPM_MODE_LOW_POWER_RUN_MODE);
    wr(LPM_OFS_CTRL, 8'h03);
    act(DO_STOP);
    act(DO_WAKE);
    chk(pwr.mode, LPM_MODE_RUN);
    rd(LPM_OFS_CTRL, 8'h02);
    wr(LPM_OFS_GATE1, 8'hff);
    wr(LPM_OFS_GATE2, 8'hff);
  endtask

  task automatic t_veto();
    for (int i = 0; i < 2; i++)
    begin
      wr(LPM_OFS_CTRL, (i == 0) ? 8'h05 : 8'h09);
      chk(pwr.mode, LPM_MODE_RUN);
      rd(LPM_OFS_STAT, 8'h08);
      act(DO_WAIT);
      chk(pwr.mode, LPM_MODE_WAIT);
      act(DO_WAKE);
      act(DO_STOP);
      chk(pwr.mode, LPM_MODE_LSTOP);
      act(DO_WAKE);
      chk(pwr.mode, LPM_MODE_RUN);
      wr(LPM_OFS_CTRL, 8'h00);
    end
  endtask

  task automatic t_stop();
    wr(LPM_OFS_CUC2, 8'h03);
    wr(LPM_OFS_CTRL, 8'h20);
    act(DO_STOP);
    chk(pwr.mode, LPM_MODE_DSTOP);
    chk(pwr.periph_clk_en, 16'h0000);
    chk(pwr.debug_clk_en, 1'b0);
    chk(pwr.osc_run, 1'b1);
    chk(pwr.adc_run_allowed, 1'b0);
    chk(pwr.regulator, REG_PARTIAL);
    chk(pwr.clock_unit_active, 1'b0);
    act(DO_WAKE);
    chk(pwr.mode, LPM_MODE_DSTOP);
    pin_pulse();
    chk(pwr.mode, LPM_MODE_RUN);
    for (int i = 0; i < 2; i++)
    begin
      wr(LPM_OFS_CTRL, (i == 0) ? 8'h24 : 8'h28);
      act(DO_STOP);
      chk(pwr.mode, LPM_MODE_LSTOP);
      chk(pwr.periph_clk_en, 16'h0000);
      chk(pwr.debug_clk_en, i == 0);
      act(DO_WAKE);
      chk(pwr.mode, LPM_MODE_RUN);
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(LPM_OFS_CUC1, (i == 0) ? 8'h03 : 8'h01);
      wr(LPM_OFS_CUC2, (i == 0) ? 8'h03 : 8'h02);
      wr(LPM_OFS_CTRL, (i == 0) ? 8'h10 : 8'h00);
      @(posedge clock);
      adc_async_clk_sel <= (i == 0);
      act(DO_STOP);
      chk(pwr.clock_unit_active, i == 0);
      chk(pwr.osc_run, i == 0);
      chk(pwr.regulator, (i == 0) ? REG_FULL : REG_STANDBY);
      chk(pwr.adc_run_allowed, i == 0);
      act(DO_WAKE);
      chk(pwr.mode, LPM_MODE_RUN);
    end
  endtask

  // reset in mid-run from light stop must land in run with registers cleared
  task automatic t_mid_reset();
    wr(LPM_OFS_CTRL, 8'h01);
    act(DO_STOP);
    chk(pwr.mode, LPM_MODE_LSTOP);
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk(pwr.mode, LPM_MODE_RUN);
    rd(LPM_OFS_CTRL, 8'h00);
  endtask

  initial
  begin
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    t_reset();
    t_low_power();
    t_veto();
    t_stop();
    t_mid_reset();
    print_verdict();
  end

  // whole run is a few hundred cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    num_errors++;
    print_verdict();
  end
endmodule
